/* File: hdl/srb_map.svh */
// Purpose: Constants for the serial read-back output path
// Assumes: 24-bit access cycles, MSB first
// Notes:   Definitions only
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH
`define SRB_FRAME_BITS   24
`define SRB_DIR_POS      23
`define SRB_ADDR_HI      22
`define SRB_ADDR_LO      16
`define SRB_DATA_HI      15
`define SRB_DATA_LO      0
`define SRB_CNT_W        5
`define SRB_ADDR_W       7
`define SRB_DATA_W       16
`endif

/* File: hdl/srb_pkg.sv */
// Purpose: Types for the serial read-back output path
// Assumes: Constants live in srb_map.svh
// Notes:   Types only
`include "srb_map.svh"
package srb_pkg;
   typedef logic [`SRB_FRAME_BITS-1:0] srb_word_t;
   typedef logic [`SRB_ADDR_W-1:0]     srb_addr_t;
   typedef logic [`SRB_DATA_W-1:0]     srb_data_t;
endpackage : srb_pkg

/* File: hdl/srb_pin_if.sv */
// Purpose: Carries synchronised link events from sampler to core
// Assumes: All signals on clk_sys_i
// Notes:   Pulses are one cycle wide
`timescale 1ns/10ps
`default_nettype none
interface srb_pin_if;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_start;
   logic sel_end;
   logic sel_act;
   logic din;
   modport src (output sclk_rise, sclk_fall, sel_start, sel_end, sel_act,
                din);
   modport dst (input sclk_rise, sclk_fall, sel_start, sel_end, sel_act,
                din);
endinterface : srb_pin_if
`default_nettype wire

/* File: hdl/srb_pin_sync.sv */
// Purpose: Three-stage sampling of link pins and edge detection
// Assumes: Link clock far slower than clk_sys_i
// Notes:   Stage one feeds only stage two
`timescale 1ns/10ps
`default_nettype none
module srb_pin_sync (
   input  wire logic   clk_sys_i,
   input  wire logic   rst_b_i,
   input  wire logic   sclk_i,
   input  wire logic   sel_b_i,
   input  wire logic   sdi_i,
   srb_pin_if.src      pins
);
   logic [2:0] sclk_ff;
   logic [2:0] sel_ff;
   logic [2:0] din_ff;
   logic       sclk_st_ff;
   logic       sel_st_ff;
   logic       din_st_ff;
   wire        sclk_ok = sclk_ff[1] == sclk_ff[2];
   wire        sel_ok  = sel_ff[1] == sel_ff[2];

   // Sampling chains and settled levels
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         sclk_ff    <= 3'h0;
         sel_ff     <= 3'h7;
         din_ff     <= 3'h0;
         sclk_st_ff <= 1'b0;
         sel_st_ff  <= 1'b1;
         din_st_ff  <= 1'b0;
      end else begin
         sclk_ff <= {sclk_ff[1:0], sclk_i};
         sel_ff  <= {sel_ff[1:0], sel_b_i};
         din_ff  <= {din_ff[1:0], sdi_i};
         if (sclk_ok) sclk_st_ff <= sclk_ff[2];
         if (sel_ok) sel_st_ff <= sel_ff[2];
         if (din_ff[1] == din_ff[2]) din_st_ff <= din_ff[2];
      end
   end

   // Edge pulses once two late stages agree
   assign pins.sclk_rise = sclk_ok && sclk_ff[2] && !sclk_st_ff;
   assign pins.sclk_fall = sclk_ok && !sclk_ff[2] && sclk_st_ff;
   assign pins.sel_start = sel_ok && !sel_ff[2] && sel_st_ff;
   assign pins.sel_end   = sel_ok && sel_ff[2] && !sel_st_ff;
   assign pins.sel_act   = !sel_st_ff;
   assign pins.din       = din_st_ff;
endmodule : srb_pin_sync
`default_nettype wire

/* File: hdl/srb_readback.sv */
// Purpose: Serial output echo and read-back of a four-wire slave port
// Assumes: Host samples on the edge opposite the chosen shift edge
// Notes:   Register contents arrive on rd_data_i, combinational lookup
// Notes on behaviour
// RULE1 - Output drives only when read-back enabled
// RULE2 - Host sends full read command cycle
// RULE3 - Data returned in the following cycle
// RULE4 - Shift edge chosen by edge select bit
// RULE5 - Bit 23 echoes previous direction bit
// RULE6 - Bits 22-16 echo previous address
// RULE7 - High-Z during command, echo next cycle
// RULE8 - Data bits of read ignored
// RULE9 - Bits 15-0 carry addressed register, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "srb_map.svh"
module srb_readback (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    sclk_i,
   input  wire logic                    sel_b_i,
   input  wire logic                    sdi_i,
   input  wire logic                    readback_output_enable_i,
   input  wire logic                    readback_edge_select_i,
   input  wire logic [`SRB_DATA_W-1:0]  rd_data_i,
   output logic      [`SRB_ADDR_W-1:0]  rd_addr_o,
   output logic                         sdo_o,
   output logic                         sdo_oe_o,
   output logic                         wr_stb_o,
   output logic      [`SRB_FRAME_BITS-1:0] wr_word_o
);
   srb_pin_if pins ();

   srb_pin_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .sclk_i    (sclk_i),
      .sel_b_i   (sel_b_i),
      .sdi_i     (sdi_i),
      .pins      (pins)
   );

   logic [`SRB_CNT_W-1:0]      cnt_ff;
   srb_pkg::srb_word_t         rx_ff;
   srb_pkg::srb_word_t         tx_ff;
   srb_pkg::srb_word_t         prev_ff;
   logic                       prev_vld_ff;
   logic                       echo_ff;
   logic [`SRB_ADDR_W-1:0]     rd_addr_ff;
   logic                       sdo_ff;
   logic                       oe_ff;
   logic                       wr_stb_ff;
   srb_pkg::srb_word_t         wr_word_ff;

   // Frame completion and chosen shift edge
   wire full_w   = cnt_ff == 5'(`SRB_FRAME_BITS);
   wire shift_w  = readback_edge_select_i ? pins.sclk_rise
                                          : pins.sclk_fall; // RULE4
   wire first_w  = cnt_ff == 5'h00;
   wire prev_rd  = prev_ff[`SRB_DIR_POS];
   // Echo word: read replaces data field with register contents
   wire [`SRB_FRAME_BITS-1:0] nxt_tx =
      prev_rd ? {prev_ff[`SRB_DIR_POS:`SRB_ADDR_LO], rd_data_i} // RULE9
              : prev_ff; // RULE5 RULE6
   wire nxt_oe = pins.sel_act && echo_ff && readback_output_enable_i; // RULE1

   // Receive shift on rising serial clock
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 5'h00;
         rx_ff  <= 24'h000000;
      end else if (pins.sel_start) begin
         cnt_ff <= 5'h00;
      end else if (pins.sel_act && pins.sclk_rise && !full_w) begin
         cnt_ff <= cnt_ff + 5'h01;
         rx_ff  <= {rx_ff[`SRB_FRAME_BITS-2:0], pins.din};
      end
   end

   // Frame close: keep command for next cycle's echo
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         prev_ff     <= 24'h000000;
         prev_vld_ff <= 1'b0;
         echo_ff     <= 1'b0;
         wr_stb_ff   <= 1'b0;
         wr_word_ff  <= 24'h000000;
      end else begin
         wr_stb_ff <= 1'b0;
         if (pins.sel_start) begin
            echo_ff     <= prev_vld_ff; // RULE3 RULE7
            prev_vld_ff <= 1'b0;
         end else if (pins.sel_end) begin
            echo_ff     <= 1'b0;
            prev_vld_ff <= full_w;
            if (full_w) begin
               prev_ff   <= rx_ff; // RULE2
               wr_stb_ff <= !rx_ff[`SRB_DIR_POS]; // RULE8
               wr_word_ff <= rx_ff;
            end
         end
      end
   end

   // Address to register file, held from frame end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) rd_addr_ff <= 7'h00;
      else rd_addr_ff <= prev_ff[`SRB_ADDR_HI:`SRB_ADDR_LO]; // RULE6
   end

   // Output shifter, MSB first; first bit loaded at frame start
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         tx_ff  <= 24'h000000;
         sdo_ff <= 1'b0;
         oe_ff  <= 1'b0;
      end else begin
         oe_ff <= nxt_oe; // RULE1 RULE7
         if (pins.sel_start) begin
            tx_ff  <= {nxt_tx[`SRB_FRAME_BITS-2:0], 1'b0};
            sdo_ff <= nxt_tx[`SRB_FRAME_BITS-1]; // RULE5
         end else if (pins.sel_act && shift_w && !first_w) begin
            tx_ff  <= {tx_ff[`SRB_FRAME_BITS-2:0], 1'b0};
            sdo_ff <= tx_ff[`SRB_FRAME_BITS-1]; // RULE4 RULE9
         end
      end
   end

   assign rd_addr_o = rd_addr_ff;
   assign sdo_o     = sdo_ff;
   assign sdo_oe_o  = oe_ff;
   assign wr_stb_o  = wr_stb_ff;
   assign wr_word_o = wr_word_ff;

   // Output never drives while read-back is disabled
   a_oe_needs_en: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      sdo_oe_o |-> $past(readback_output_enable_i)) // RULE1
      else $error("output driven while disabled");

   // No drive outside a selected frame
   a_oe_in_frame: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $past(!pins.sel_act) |-> !sdo_oe_o) // RULE7
      else $error("output driven outside frame");

   // Echo only in frame following a complete one
   a_echo_after: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.sel_start && !prev_vld_ff |=> !echo_ff) // RULE3
      else $error("echo without preceding command");

   // First echoed bit is the stored direction bit
   a_dir_echo: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.sel_start |=> sdo_o == $past(prev_ff[`SRB_DIR_POS])) // RULE5
      else $error("direction bit not echoed");

   // Address bus follows stored address
   a_addr_echo: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      ##1 rd_addr_o == $past(prev_ff[`SRB_ADDR_HI:`SRB_ADDR_LO])) // RULE6
      else $error("address not presented");

   // Read commands never strobe a write
   a_read_no_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_stb_o |-> !wr_word_o[`SRB_DIR_POS]) // RULE8
      else $error("read produced write");

   // Output only changes on chosen edge or frame start
   a_shift_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $changed(sdo_o) |-> $past(pins.sel_start || shift_w)) // RULE4
      else $error("output moved off shift edge");

   // Read data loaded behind echoed header
   a_read_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      pins.sel_start && prev_rd |=>
         tx_ff[`SRB_DATA_HI+1:1] == $past(rd_data_i)) // RULE9
      else $error("register data not loaded");
endmodule : srb_readback
`default_nettype wire

/* File: sim/srb_host_model.sv */
// Purpose: Behavioural SPI host for the read-back path
// Assumes: Link clock idles low, 80 ns period
// Notes:   Samples on the edge opposite the shift edge
`timescale 1ns/10ps
`default_nettype none
module srb_host_model (
   input  wire logic sdo_i,
   input  wire logic es_i,
   output var  logic sclk_o,
   output var  logic sel_b_o,
   output var  logic sdi_o
);
   // Idle link
   initial begin
      sclk_o = 1'h0;
      sel_b_o = 1'h1;
      sdi_o = 1'h0;
   end
   // One access cycle of n bits, MSB first
   task automatic frame(input logic [23:0] tx, input int n,
                        output logic [23:0] rx);
      rx = 24'h000000;
      #1.3;
      sel_b_o = 1'h0;
      for (int i = 0; i < n; i++) begin
         sdi_o = tx[23-i];
         #40;
         if (!es_i) rx = {rx[22:0], sdo_i};
         sclk_o = 1'h1;
         #40;
         if (es_i) rx = {rx[22:0], sdo_i};
         sclk_o = 1'h0;
      end
      #40;
      sel_b_o = 1'h1;
      sdi_o = ~sdi_o; // Released line does not hold
      #80;
   endtask : frame
endmodule : srb_host_model
`default_nettype wire

/* File: sim/srb_readback_bench.sv */
// Purpose: Self-checking bench for the serial read-back path
// Assumes: Register contents derived from the address
// Notes:   Host model drives the link pins
`timescale 1ns/10ps
`default_nettype none
`include "srb_map.svh"
module srb_readback_bench;
   logic                       clk_sys_i = 1'h0;
   logic                       rst_b_i = 1'h0;
   logic                       en = 1'h0;
   logic                       es = 1'h0;
   logic                       sclk, sel_b, sdi, sdo, sdo_oe, sdo_pin;
   logic                       sdo_last = 1'h0;
   logic                       oe_hit = 1'h0;
   logic [`SRB_ADDR_W-1:0]     rd_addr;
   logic [`SRB_DATA_W-1:0]     rd_data;
   logic [`SRB_FRAME_BITS-1:0] rx;
   int                         n_fail = 0;
   int                         total_checks = 0;
   function automatic logic [15:0] reg_val(input logic [6:0] a);
      return {~a, 2'h2, a};
   endfunction : reg_val
   // Clock, register file, pin level and drive monitor
   always #2 clk_sys_i = ~clk_sys_i;
   assign rd_data = reg_val(rd_addr);
   assign sdo_pin = sdo_oe ? sdo : ~sdo_last;
   always @(posedge clk_sys_i) begin
      if (sdo_oe) sdo_last <= sdo;
      if (sdo_oe) oe_hit <= 1'h1;
   end
   srb_readback DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .sclk_i(sclk), .sel_b_i(sel_b), .sdi_i(sdi),
      .readback_output_enable_i(en), .readback_edge_select_i(es),
      .rd_data_i(rd_data), .rd_addr_o(rd_addr), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .wr_stb_o(), .wr_word_o());
   srb_host_model host (.sdo_i(sdo_pin), .es_i(es), .sclk_o(sclk),
      .sel_b_o(sel_b), .sdi_o(sdi));
   task automatic chk(input string what, input logic [23:0] exp,
                      input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // Set enable and edge select, clear drive monitor
   task automatic cfg(input logic en_v, input logic es_v);
      @(posedge clk_sys_i);
      en <= en_v;
      es <= es_v;
      oe_hit <= 1'h0;
      @(posedge clk_sys_i);
   endtask : cfg
   task automatic t_disabled;
      cfg(1'h0, 1'h0);
      host.frame(24'h85FFFF, 24, rx);
      host.frame(24'h000000, 24, rx);
      chk("oe while disabled", 24'h0, {23'h0, oe_hit});
      $display("test disabled done");
   endtask : t_disabled
   // Back-to-back reads, host data bits are junk
   task automatic t_read(input logic es_v);
      cfg(1'h1, es_v);
      host.frame(24'hDA3C3C, 24, rx);
      host.frame(24'hA1F0F0, 24, rx);
      chk("read echo", {8'hDA, reg_val(7'h5A)}, rx);
      host.frame(24'h000000, 24, rx);
      chk("next read echo", {8'hA1, reg_val(7'h21)}, rx);
      $display("test read done");
   endtask : t_read
   // Short frame, write command, echo, release
   task automatic t_write;
      cfg(1'h1, 1'h1);
      host.frame(24'h3B1234, 23, rx);
      cfg(1'h1, 1'h1);
      host.frame(24'h3B1234, 24, rx);
      chk("oe in write command", 24'h0, {23'h0, oe_hit});
      host.frame(24'h800000, 24, rx);
      chk("write echo", 24'h3B1234, rx);
      cfg(1'h1, 1'h1);
      repeat (40) @(posedge clk_sys_i);
      chk("oe after echo", 24'h0, {23'h0, oe_hit});
      $display("test write done");
   endtask : t_write
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_b_i <= 1'h1;
      repeat (4) @(posedge clk_sys_i);
      t_disabled();
      t_read(1'h0);
      t_read(1'h1);
      t_write();
      end_of_test();
   end
   // Hang limit
   initial begin
      #200000;
      n_fail++;
      $display("CHECK FAILED watchdog exp done got hang");
      end_of_test();
   end
endmodule : srb_readback_bench
`default_nettype wire
